// file: pmio_pkg.sv
// shared constants for the power-management i/o configuration block
package pmio_pkg;
	localparam int unsigned CLK_PERIOD_NS = 40;
	// one ramp step time, the time per code at the fastest slew setting, in ns
	localparam int unsigned STEP_TIME_NS = 1000;
	localparam int unsigned STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned VSEL_W = 6;
	localparam int unsigned SLEW_W = 3;

	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_USER = 8'h04;
	localparam logic [7:0] ADDR_RAIL1 = 8'h08;
	localparam logic [7:0] ADDR_RAIL2 = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	localparam int unsigned CFG_DDR_SEL_BIT = 0;
	localparam int unsigned CFG_DRIVE_BIT = 1;
	localparam int unsigned CFG_CORE_RST_BIT = 2;
	localparam int unsigned CFG_SLEW_LSB = 4;
	localparam int unsigned USER_PIN1_BIT = 0;
	localparam int unsigned USER_PIN2_BIT = 1;
	localparam int unsigned USER_PIN3_BIT = 2;
	localparam int unsigned ST_PIN1_BIT = 0;
	localparam int unsigned ST_PIN3_BIT = 1;
	localparam int unsigned ST_PG_BIT = 2;
	localparam int unsigned ST_LATCH_BIT = 3;
	localparam int unsigned ST_RAIL1_LSB = 8;
	localparam int unsigned ST_RAIL2_LSB = 16;

	localparam logic RST_DDR_SEL = 1'b0;
	localparam logic RST_DRIVE = 1'b0;
	localparam logic RST_CORE_RST = 1'b0;
	localparam logic [SLEW_W-1:0] RST_SLEW = 3'h0;
	localparam logic [2:0] RST_USER = 3'h7;
	localparam logic [VSEL_W-1:0] RAIL1_DEFAULT = 6'h0A;
	localparam logic [VSEL_W-1:0] RAIL2_DEFAULT = 6'h0A;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: pmio_top.sv
// i/o configuration, ddr reset pass/latch and core rail warm reset
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module pmio_top
	import pmio_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [7:0]        s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [7:0]        s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	output logic                   s_axi_rready_unused_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              rails_in_reg_i,
	input  wire logic              any_rail_enabled_i,
	input  wire logic              suspend_i,
	input  wire logic              seq_pin_one_low_i,
	input  wire logic              seq_pin_three_low_i,
	input  wire logic              first_io_pin_i,
	output logic                   first_io_pin_o,
	output logic                   first_io_pin_oe_o,
	output logic                   second_output_pin_o,
	output logic                   second_output_pin_oe_o,
	input  wire logic              third_io_pin_i,
	output logic                   third_io_pin_o,
	output logic                   third_io_pin_oe_o,
	output logic                   main_power_good_o,
	output logic [VSEL_W-1:0]      core_buck_rail_one_vsel_o,
	output logic [VSEL_W-1:0]      core_buck_rail_two_vsel_o
);
	logic                rst_meta_q;
	logic                rst_sync_q;
	logic                pin1_meta_q;
	logic                pin1_s_q;
	logic                pin3_meta_q;
	logic                pin3_s_q;
	logic                pin3_prev_q;
	logic                pin3_fall;
	logic                ddr_reset_input_select_q;
	logic                second_output_drive_type_q;
	logic                core_rail_reset_enable_q;
	logic [SLEW_W-1:0]   slew_q;
	logic                pin_one_output_bit_q;
	logic                second_output_pin_bit_q;
	logic                pin_three_output_bit_q;
	logic [VSEL_W-1:0]   rail1_tgt_q;
	logic [VSEL_W-1:0]   rail2_tgt_q;
	logic [VSEL_W-1:0]   rail1_act_q;
	logic [VSEL_W-1:0]   rail2_act_q;
	logic [15:0]         step_cnt_q;
	logic                step_tick;
	logic                pg_q;
	logic                ddr_latch_q;
	logic                ddr_level;
	logic                pin2_level;
	logic [7:0]          awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                wr_fire;
	logic                wr_lane0;
	logic [31:0]         rd_value;
	logic                rd_hit;

	// step toward the target by one code
	function automatic logic [VSEL_W-1:0] ramp_step(input logic [VSEL_W-1:0] act, input logic [VSEL_W-1:0] tgt);
		if (act < tgt) begin
			ramp_step = act + VSEL_W'(1);
		end else if (act > tgt) begin
			ramp_step = act - VSEL_W'(1);
		end else begin
			ramp_step = act;
		end
	endfunction

	// true for the five word offsets that hold registers
	function automatic logic addr_mapped(input logic [7:0] addr);
		addr_mapped = (addr == ADDR_CFG) || (addr == ADDR_USER) || (addr == ADDR_RAIL1) ||
			(addr == ADDR_RAIL2) || (addr == ADDR_STATUS);
	endfunction

	// reset asserts at once but leaves through two flops, so no flop sees a release mid-setup
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// pins are asynchronous to the internal clock
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin1_meta_q <= 1'b1;
			pin1_s_q <= 1'b1;
			pin3_meta_q <= 1'b1;
			pin3_s_q <= 1'b1;
			pin3_prev_q <= 1'b1;
		end else begin
			pin1_meta_q <= first_io_pin_i;
			pin1_s_q <= pin1_meta_q;
			pin3_meta_q <= third_io_pin_i;
			pin3_s_q <= pin3_meta_q;
			pin3_prev_q <= pin3_s_q;
		end
	end

	// edge looked for only while enabled, so turning the reset on never reloads the rails
	assign pin3_fall = core_rail_reset_enable_q & pin3_prev_q & ~pin3_s_q;

	// power-good from the supervisor view
	// reaches its pin two edges after the supervisor inputs change
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pg_q <= 1'b0;
		end else begin
			pg_q <= rails_in_reg_i & any_rail_enabled_i & ~suspend_i;
		end
	end

	// tracks while power-good is high, so it holds the level seen at the fall
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ddr_latch_q <= 1'b0;
		end else if (pg_q) begin
			ddr_latch_q <= pin1_s_q;
		end
	end

	assign ddr_level = pg_q ? pin1_s_q : ddr_latch_q;
	// user bit is ignored while pin one carries the ddr reset
	assign pin2_level = ddr_reset_input_select_q ? ddr_level : second_output_pin_bit_q;

	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			first_io_pin_o <= 1'b0;
			first_io_pin_oe_o <= 1'b0;
			second_output_pin_o <= 1'b0;
			second_output_pin_oe_o <= 1'b0;
			third_io_pin_o <= 1'b0;
			third_io_pin_oe_o <= 1'b0;
			main_power_good_o <= 1'b0;
		end else begin
			first_io_pin_o <= 1'b0;
			first_io_pin_oe_o <= ~ddr_reset_input_select_q & (~pin_one_output_bit_q | seq_pin_one_low_i);
			if (second_output_drive_type_q) begin
				second_output_pin_o <= pin2_level;
				second_output_pin_oe_o <= 1'b1;
			end else begin
				second_output_pin_o <= 1'b0;
				second_output_pin_oe_o <= ~pin2_level;
			end
			third_io_pin_o <= 1'b0;
			third_io_pin_oe_o <= ~core_rail_reset_enable_q & (~pin_three_output_bit_q | seq_pin_three_low_i);
			main_power_good_o <= pg_q;
		end
	end

	// write path: address and data taken in either order, one write at a time
	assign wr_fire = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
	assign wr_lane0 = wr_fire & wstrb_q[0];

	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				awaddr_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ddr_reset_input_select_q <= RST_DDR_SEL;
			second_output_drive_type_q <= RST_DRIVE;
			core_rail_reset_enable_q <= RST_CORE_RST;
			slew_q <= RST_SLEW;
			pin_one_output_bit_q <= RST_USER[USER_PIN1_BIT];
			second_output_pin_bit_q <= RST_USER[USER_PIN2_BIT];
			pin_three_output_bit_q <= RST_USER[USER_PIN3_BIT];
		end else if (wr_lane0) begin
			if (awaddr_q == ADDR_CFG) begin
				ddr_reset_input_select_q <= wdata_q[CFG_DDR_SEL_BIT];
				second_output_drive_type_q <= wdata_q[CFG_DRIVE_BIT];
				core_rail_reset_enable_q <= wdata_q[CFG_CORE_RST_BIT];
				slew_q <= wdata_q[CFG_SLEW_LSB +: SLEW_W];
			end
			if (awaddr_q == ADDR_USER) begin
				pin_one_output_bit_q <= wdata_q[USER_PIN1_BIT];
				second_output_pin_bit_q <= wdata_q[USER_PIN2_BIT];
				pin_three_output_bit_q <= wdata_q[USER_PIN3_BIT];
			end
		end
	end

	// the warm reset beats a software write in the same cycle
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rail1_tgt_q <= RAIL1_DEFAULT;
			rail2_tgt_q <= RAIL2_DEFAULT;
		end else if (pin3_fall) begin
			rail1_tgt_q <= RAIL1_DEFAULT;
			rail2_tgt_q <= RAIL2_DEFAULT;
		end else if (wr_lane0) begin
			if (awaddr_q == ADDR_RAIL1) begin
				rail1_tgt_q <= wdata_q[VSEL_W-1:0];
			end
			if (awaddr_q == ADDR_RAIL2) begin
				rail2_tgt_q <= wdata_q[VSEL_W-1:0];
			end
		end
	end

	// ramp pacing: one code per (slew+1) step times, rails never turned off
	assign step_tick = (step_cnt_q == 16'h0000);

	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			step_cnt_q <= 16'h0000;
			rail1_act_q <= RAIL1_DEFAULT;
			rail2_act_q <= RAIL2_DEFAULT;
			core_buck_rail_one_vsel_o <= RAIL1_DEFAULT;
			core_buck_rail_two_vsel_o <= RAIL2_DEFAULT;
		end else begin
			if (step_tick) begin
				step_cnt_q <= 16'((32'(slew_q) + 32'd1) * STEP_CYC - 32'd1);
				rail1_act_q <= ramp_step(rail1_act_q, rail1_tgt_q);
				rail2_act_q <= ramp_step(rail2_act_q, rail2_tgt_q);
			end else begin
				step_cnt_q <= step_cnt_q - 16'h0001;
			end
			core_buck_rail_one_vsel_o <= rail1_act_q;
			core_buck_rail_two_vsel_o <= rail2_act_q;
		end
	end

	// read data is registered at the address handshake, one cycle behind arvalid
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit = addr_mapped(s_axi_araddr_i);
		case (s_axi_araddr_i)
			ADDR_CFG: begin
				rd_value[CFG_DDR_SEL_BIT] = ddr_reset_input_select_q;
				rd_value[CFG_DRIVE_BIT] = second_output_drive_type_q;
				rd_value[CFG_CORE_RST_BIT] = core_rail_reset_enable_q;
				rd_value[CFG_SLEW_LSB +: SLEW_W] = slew_q;
			end
			ADDR_USER: begin
				rd_value[USER_PIN1_BIT] = pin_one_output_bit_q;
				rd_value[USER_PIN2_BIT] = second_output_pin_bit_q;
				rd_value[USER_PIN3_BIT] = pin_three_output_bit_q;
			end
			ADDR_RAIL1: begin
				rd_value[VSEL_W-1:0] = rail1_tgt_q;
			end
			ADDR_RAIL2: begin
				rd_value[VSEL_W-1:0] = rail2_tgt_q;
			end
			ADDR_STATUS: begin
				rd_value[ST_PIN1_BIT] = pin1_s_q;
				rd_value[ST_PIN3_BIT] = pin3_s_q;
				rd_value[ST_PG_BIT] = pg_q;
				rd_value[ST_LATCH_BIT] = ddr_latch_q;
				rd_value[ST_RAIL1_LSB +: VSEL_W] = rail1_act_q;
				rd_value[ST_RAIL2_LSB +: VSEL_W] = rail2_act_q;
			end
			default: begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RESP_OKAY;
			s_axi_rready_unused_o <= 1'b0;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_value;
				s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end
endmodule

// file: pmio_host_model.sv
// host processor model driving the ddr reset and core rail reset lines
`timescale 1ns/1ns
module pmio_host_model (
	input  wire logic clk_i,
	input  wire logic ddr_rst_n_i,
	input  wire logic core_rst_n_i,
	input  wire logic slow_i,
	input  wire logic pin_one_oe_i,
	input  wire logic pin_three_oe_i,
	output logic      pin_one_o,
	output logic      pin_three_o
);
	logic ddr_q = 1'h1;
	logic ddr_s = 1'h1;
	logic core_q = 1'h1;
	always @(posedge clk_i) begin
		ddr_q <= ddr_rst_n_i;
		ddr_s <= ddr_q;
		core_q <= core_rst_n_i;
	end
	// pulled-up lines, so a device pull-down always wins
	assign pin_one_o = (slow_i ? ddr_s : ddr_q) & ~pin_one_oe_i;
	assign pin_three_o = core_q & ~pin_three_oe_i;
endmodule

// file: pmio_assertions.sv
// checker for power-good, pin drive, ramp and register bus timing
`timescale 1ns/1ns
module pmio_assertions
	import pmio_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic [7:0]        s_axi_araddr_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [1:0]        s_axi_rresp_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_awvalid_i,
	input wire logic              s_axi_awready_o,
	input wire logic              s_axi_wvalid_i,
	input wire logic              s_axi_wready_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic              rails_in_reg_i,
	input wire logic              any_rail_enabled_i,
	input wire logic              suspend_i,
	input wire logic              first_io_pin_o,
	input wire logic              third_io_pin_o,
	input wire logic              main_power_good_o,
	input wire logic [VSEL_W-1:0] core_buck_rail_one_vsel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_pg_off: assert property (!any_rail_enabled_i |-> ##2 !main_power_good_o)
		else $error("power good with no rail");
	chk_pg_susp: assert property (suspend_i |-> ##2 !main_power_good_o)
		else $error("power good in suspend");
	chk_pg_rise: assert property ($rose(main_power_good_o) |->
		$past(rails_in_reg_i, 2) && $past(any_rail_enabled_i, 2) && !$past(suspend_i, 2))
		else $error("power good without regulation");
	chk_pin1_low: assert property (first_io_pin_o == 1'h0)
		else $error("pin one driven high");
	chk_pin3_low: assert property (third_io_pin_o == 1'h0)
		else $error("pin three driven high");
	chk_ramp_step: assert property ($changed(core_buck_rail_one_vsel_o) |->
		(core_buck_rail_one_vsel_o - $past(core_buck_rail_one_vsel_o)) inside {6'h01, 6'h3F})
		else $error("rail code jumped");
	chk_wr_resp: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
		else $error("write response late");
	chk_rd_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read response late");
	chk_rd_err: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > ADDR_STATUS
		|=> s_axi_rresp_o == RESP_SLVERR)
		else $error("unmapped read accepted");
endmodule
bind pmio_top pmio_assertions u_chk (.clk_i, .rst_n_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
	.s_axi_bvalid_o, .rails_in_reg_i, .any_rail_enabled_i, .suspend_i, .first_io_pin_o, .third_io_pin_o,
	.main_power_good_o, .core_buck_rail_one_vsel_o);

// file: pmio_top_tb_top.sv
// self-checking bench for the i/o configuration block
`timescale 1ns/1ns
module pmio_top_tb_top import pmio_pkg::*;;
	logic clk_i = 1'h0, rst_n_i = 1'h0, s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, rails_in_reg_i = 1'h0, any_rail_enabled_i = 1'h0;
	logic suspend_i = 1'h0, seq_pin_one_low_i = 1'h0, seq_pin_three_low_i = 1'h0;
	logic ddr_n = 1'h1, core_n = 1'h1, slow = 1'h0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	wire logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	wire logic [31:0] s_axi_rdata_o;
	wire logic first_io_pin_i, first_io_pin_o, first_io_pin_oe_o, second_output_pin_o, second_output_pin_oe_o;
	wire logic third_io_pin_i, third_io_pin_o, third_io_pin_oe_o, main_power_good_o;
	wire logic [VSEL_W-1:0] core_buck_rail_one_vsel_o, core_buck_rail_two_vsel_o;
	int bad_count = 0, compares = 0, cyc = 0;
	pmio_top dut (.clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_unused_o(), .s_axi_rready_i, .rails_in_reg_i, .any_rail_enabled_i, .suspend_i,
		.seq_pin_one_low_i, .seq_pin_three_low_i, .first_io_pin_i, .first_io_pin_o, .first_io_pin_oe_o,
		.second_output_pin_o, .second_output_pin_oe_o, .third_io_pin_i, .third_io_pin_o, .third_io_pin_oe_o,
		.main_power_good_o, .core_buck_rail_one_vsel_o, .core_buck_rail_two_vsel_o);
	pmio_host_model host (.clk_i, .ddr_rst_n_i(ddr_n), .core_rst_n_i(core_n), .slow_i(slow),
		.pin_one_oe_i(first_io_pin_oe_o), .pin_three_oe_i(third_io_pin_oe_o), .pin_one_o(first_io_pin_i),
		.pin_three_o(third_io_pin_i));
	always #20 clk_i = ~clk_i;
	task automatic complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// payload released only at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		logic tb = 1'h0;
		logic [1:0] rs;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		while (!tb) begin
			#1;
			ta = s_axi_awvalid_i && s_axi_awready_o;
			tw = s_axi_wvalid_i && s_axi_wready_o;
			tb = s_axi_bvalid_o;
			rs = s_axi_bresp_o;
			@(posedge clk_i);
			if (ta) s_axi_awvalid_i <= 1'h0;
			if (tw) s_axi_wvalid_i <= 1'h0;
		end
		s_axi_bready_i <= 1'h0;
		ck("bresp", rs, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta;
		logic tr = 1'h0;
		logic [1:0] rs;
		logic [31:0] rv;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		while (!tr) begin
			#1;
			ta = s_axi_arvalid_i && s_axi_arready_o;
			tr = s_axi_rvalid_o;
			rs = s_axi_rresp_o;
			rv = s_axi_rdata_o;
			@(posedge clk_i);
			if (ta) s_axi_arvalid_i <= 1'h0;
		end
		s_axi_rready_i <= 1'h0;
		ck("rresp", rs, er);
		ck("rdata", rv, ed);
	endtask
	task automatic t_regs;
		rd(ADDR_CFG, 32'h0, RESP_OKAY);
		rd(ADDR_USER, 32'h7, RESP_OKAY);
		wr(8'h20, 32'h0, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		s_axi_wstrb_i <= 4'hE;
		wr(ADDR_CFG, 32'h7, RESP_OKAY);
		s_axi_wstrb_i <= 4'hF;
		rd(ADDR_CFG, 32'h0, RESP_OKAY);
	endtask
	task automatic t_pin1;
		wr(ADDR_USER, 32'h6, RESP_OKAY);
		wt(6);
		#1 ck("pin1 oe", first_io_pin_oe_o, 1'h1);
		wr(ADDR_USER, 32'h7, RESP_OKAY);
		wt(6);
		#1 ck("pin1 oe", first_io_pin_oe_o, 1'h0);
		seq_pin_one_low_i <= 1'h1;
		wt(6);
		#1 ck("pin1 oe", first_io_pin_oe_o, 1'h1);
		seq_pin_one_low_i <= 1'h0;
	endtask
	task automatic t_pin2;
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CFG, {30'h0, m[0], 1'h0}, RESP_OKAY);
			wr(ADDR_USER, {29'h0, 1'h1, m[1], 1'h1}, RESP_OKAY);
			wt(6);
			#1 ck("pin2 oe", second_output_pin_oe_o, m[0] | !m[1]);
			ck("pin2", second_output_pin_o & second_output_pin_oe_o, m[1] & m[0]);
		end
	endtask
	// second user bit held low to show it is ignored
	task automatic t_ddr;
		wr(ADDR_USER, 32'h5, RESP_OKAY);
		for (int d = 0; d < 2; d++) begin
			slow <= d[0];
			wr(ADDR_CFG, {30'h0, d[0], 1'h1}, RESP_OKAY);
			wt(6);
			#1 ck("ddr", {second_output_pin_oe_o, second_output_pin_o}, 2'h2);
			rails_in_reg_i <= 1'h1;
			any_rail_enabled_i <= 1'h1;
			suspend_i <= 1'h0;
			wt(8);
			#1 ck("ddr", {second_output_pin_oe_o, second_output_pin_o & d[0]}, {2{d[0]}});
			suspend_i <= 1'h1;
			wt(4);
			ddr_n <= 1'h0;
			wt(8);
			#1 ck("ddr", {second_output_pin_oe_o, second_output_pin_o & d[0]}, {2{d[0]}});
			suspend_i <= 1'h0;
			wt(8);
			#1 ck("ddr", {second_output_pin_oe_o, second_output_pin_o}, 2'h2);
			suspend_i <= 1'h1;
			ddr_n <= 1'h1;
			wt(8);
			#1 ck("ddr", {second_output_pin_oe_o, second_output_pin_o}, 2'h2);
		end
		suspend_i <= 1'h0;
		any_rail_enabled_i <= 1'h0;
	endtask
	task automatic t_pg;
		wt(3);
		#1 ck("pg", main_power_good_o, 1'h0);
		any_rail_enabled_i <= 1'h1;
		wt(3);
		#1 ck("pg", main_power_good_o, 1'h1);
		rails_in_reg_i <= 1'h0;
		wt(3);
		#1 ck("pg", main_power_good_o, 1'h0);
		rails_in_reg_i <= 1'h1;
		wt(3);
		#1 ck("pg", main_power_good_o, 1'h1);
		suspend_i <= 1'h1;
		wt(3);
		#1 ck("pg", main_power_good_o, 1'h0);
		suspend_i <= 1'h0;
	endtask
	task automatic t_core;
		wr(ADDR_CFG, 32'h0, RESP_OKAY);
		wr(ADDR_USER, 32'h3, RESP_OKAY);
		wt(6);
		#1 ck("pin3 oe", third_io_pin_oe_o, 1'h1);
		seq_pin_three_low_i <= 1'h1;
		wr(ADDR_USER, 32'h7, RESP_OKAY);
		wt(6);
		#1 ck("pin3 oe", third_io_pin_oe_o, 1'h1);
		seq_pin_three_low_i <= 1'h0;
		wr(ADDR_CFG, 32'h4, RESP_OKAY);
		wr(ADDR_USER, 32'h3, RESP_OKAY);
		wr(ADDR_RAIL1, 32'hC, RESP_OKAY);
		wr(ADDR_RAIL2, 32'h8, RESP_OKAY);
		wt(6);
		#1 ck("pin3 oe", third_io_pin_oe_o, 1'h0);
		wt(100);
		#1 ck("rail1", core_buck_rail_one_vsel_o, 6'h0C);
		ck("rail2", core_buck_rail_two_vsel_o, 6'h08);
		core_n <= 1'h0;
		wt(100);
		#1 ck("rail1", core_buck_rail_one_vsel_o, RAIL1_DEFAULT);
		ck("rail2", core_buck_rail_two_vsel_o, RAIL2_DEFAULT);
		rd(ADDR_CFG, 32'h4, RESP_OKAY);
		rd(ADDR_USER, 32'h3, RESP_OKAY);
		rd(ADDR_RAIL1, 32'(RAIL1_DEFAULT), RESP_OKAY);
		rd(ADDR_STATUS, {10'h0, RAIL2_DEFAULT, 2'h0, RAIL1_DEFAULT, 4'h0, 4'hD}, RESP_OKAY);
		core_n <= 1'h1;
	endtask
	initial begin
		wt(12);
		rst_n_i <= 1'h1;
		wt(3);
		t_regs();
		t_pin1();
		t_pin2();
		t_ddr();
		t_pg();
		t_core();
		complete_run();
	end
endmodule
